// ---- core/timer_pwm_regs.vh ----
// timer_pwm_regs.vh: constants for the timer pwm channel logic
// assumes inclusion by bare name from the core/ design files
`ifndef TIMER_PWM_REGS_VH
`define TIMER_PWM_REGS_VH

// counter and value width
`define CNT_W 16
// modulo register comes out of reset at all ones
`define MOD_RESET 16'hFFFF
`define CNT_RESET 16'h0000
// prescaler width covers divide by 64
`define DIV_W 6
`define DIV_RESET 6'h00
// divider code that yields no tick at all
`define DIV_NONE 3'h7
// edge/level codes for output compare
`define ELS_OFF 2'h0
`define ELS_TOGGLE 2'h1
`define ELS_CLEAR 2'h2
`define ELS_SET 2'h3
// flag vector positions
`define FLG_ROLL 0
`define FLG_CH0 1
`define FLG_CH1 2
`define FLG_N 3

`endif

// ---- core/tick_prescaler.v ----
// tick_prescaler: divides the bus clock into timer ticks
// assumes div_sel and clear come from logic on clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "timer_pwm_regs.vh"

module tick_prescaler
(
	input  wire       clk_sys,
	input  wire       reset_n,
	input  wire       run,
	input  wire       clear,
	input  wire [2:0] div_sel,
	output wire       tick
);

	reg  [`DIV_W-1:0] div_reg;
	wire [`DIV_W-1:0] mask;

	// mask of low bits that must all be one for a tick
	assign mask = ~({`DIV_W{1'b1}} << div_sel);

	// code 7 is unavailable: it must never tick
	assign tick = run && (div_sel != `DIV_NONE) &&
		((div_reg & mask) == mask);

	// free divider, zeroed together with the counter
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			div_reg <= `DIV_RESET;
		else if (clear)
			div_reg <= `DIV_RESET;
		else if (run)
			div_reg <= div_reg + 6'h01;
	end

endmodule
`default_nettype wire

// ---- core/chan_pin_logic.v ----
// chan_pin_logic: registered pin level of one compare channel
// assumes rollover and compare events are one-cycle tick pulses
`timescale 1ns/1ps
`default_nettype none
`include "timer_pwm_regs.vh"

module chan_pin_logic
(
	input  wire       clk_sys,
	input  wire       reset_n,
	input  wire       rollover_ev,
	input  wire       compare_ev,
	input  wire [1:0] els,
	input  wire       mode_sel,
	input  wire       tov,
	input  wire       full_duty,
	output reg        pin_reg
);

	reg pin_next;

	// rollover first, compare after, so compare wins a tie
	always @*
	begin
		pin_next = pin_reg;
		if (els == `ELS_OFF)
			pin_next = ~mode_sel; // initial level select
		else if (mode_sel)
		begin
			// rollover restores the pulse level
			if (rollover_ev && tov)
			begin
				if (els == `ELS_TOGGLE)
					pin_next = ~pin_reg;
				else
					pin_next = ~els[0];
			end
			// full duty with rollover toggle masks the compare, pin stays at pulse level
			if (compare_ev && !(full_duty && tov))
			begin
				if (els == `ELS_TOGGLE)
					pin_next = ~pin_next;
				else
					pin_next = els[0];
			end
		end
	end

	// pin level is always a flip-flop, never a gate
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			pin_reg <= 1'b0;
		else
			pin_reg <= pin_next;
	end

endmodule
`default_nettype wire

// ---- core/timer_pwm_channel_logic.v ----
// timer_pwm_channel_logic: 16-bit timer with two pwm channels
// assumes control ports come from cpu-side logic on clk_sys;
// flag clears arrive as read and write-zero strobes.
//
// Contract
// - toggle pin at rollover when enabled
// - period is modulo plus one ticks
// - compare value sets the pulse width
// - unbuffered value write takes effect immediately
// - link bit pairs channels onto pin zero
// - rollover switches to last written value
// - linked mode frees channel one pin
// - no rollover toggle gives zero duty
// - full duty plus toggle gives 100 percent
// - rollover flag, interrupt only when enabled
// - channel flag, interrupt only when enabled
// - wait keeps counting, blocks register access
// - stop freezes counter and keeps state
// - break freezes the counter
// - break clears flags only when enabled
// - armed clear survives protected break
// - read-then-write-zero clear, set wins
// - divider select, code seven unavailable
// - counter clear zeroes counter and prescaler
// - restart from zero after modulo
`timescale 1ns/1ps
`default_nettype none
`include "timer_pwm_regs.vh"

module timer_pwm_channel_logic
#(
	parameter CW = `CNT_W
)
(
	input  wire          clk_sys,
	input  wire          reset_n,
	input  wire          counter_halt_bit,
	input  wire          counter_clear_bit,
	input  wire [2:0]    tick_divider_sel,
	input  wire          modulo_wr,
	input  wire [CW-1:0] modulo_wdata,
	input  wire          chan0_value_wr,
	input  wire          chan1_value_wr,
	input  wire [CW-1:0] value_wdata,
	input  wire          buffer_link_sel,
	input  wire [1:0]    chan_mode_sel,
	input  wire [1:0]    edge_level_sel_hi,
	input  wire [1:0]    edge_level_sel_lo,
	input  wire [1:0]    toggle_on_rollover,
	input  wire [1:0]    full_duty_sel,
	input  wire          rollover_irq_en,
	input  wire [1:0]    chan_irq_en,
	input  wire          timer_stat_rd,
	input  wire          rollover_flag_wr0,
	input  wire [1:0]    chan_stat_rd,
	input  wire [1:0]    chan_flag_wr0,
	input  wire          wait_active,
	input  wire          stop_active,
	input  wire          break_active,
	input  wire          break_clear_enable,
	output reg  [CW-1:0] counter_reg,
	output reg  [CW-1:0] modulo_reg,
	output reg  [CW-1:0] chan0_value_reg,
	output reg  [CW-1:0] chan1_value_reg,
	output reg           active_chan_reg,
	output wire          rollover_flag,
	output wire [1:0]    chan_event_flag,
	output reg           rollover_irq_reg,
	output reg  [1:0]    chan_irq_reg,
	output reg           wake_req_reg,
	output wire          chan0_pin,
	output wire          chan1_pin,
	output reg           chan1_pin_en_reg
);

	wire          run;
	wire          tick;
	wire [CW-1:0] count_inc;
	wire          roll_ev;
	wire [CW-1:0] count_after;
	wire [CW-1:0] cmp0_val;
	wire [1:0]    els0;
	wire [1:0]    els1;
	wire          oc0;
	wire          oc1;
	wire          cmp_ev0;
	wire          cmp_ev1;
	wire          acc_ok;
	wire [`FLG_N-1:0] flag_set;
	wire [`FLG_N-1:0] flag_rd;
	wire [`FLG_N-1:0] flag_wr0;
	reg  [`FLG_N-1:0] flag_reg;
	reg  [`FLG_N-1:0] flag_next;
	reg  [`FLG_N-1:0] armed_reg;
	reg  [`FLG_N-1:0] armed_next;
	reg               pending_reg;
	reg               pending_next;
	reg               active_next;
	reg  [CW-1:0]     counter_next;

	// counting stops for halt, stop state and break; wait keeps it
	assign run = !counter_halt_bit && !stop_active &&
		!break_active;

	tick_prescaler u_prescaler
	(
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.run     (run),
		.clear   (counter_clear_bit),
		.div_sel (tick_divider_sel),
		.tick    (tick)
	);

	assign count_inc = counter_reg + 16'h0001;

	// rollover on the tick that finds the counter at modulo
	assign roll_ev = tick && !counter_clear_bit &&
		(counter_reg == modulo_reg);

	// value the counter holds after this tick
	assign count_after = roll_ev ? `CNT_RESET : count_inc;

	// counter register, cleared by the clear pulse
	always @*
	begin
		counter_next = counter_reg;
		if (counter_clear_bit)
			counter_next = `CNT_RESET;
		else if (tick)
			counter_next = count_after;
	end

	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			counter_reg <= `CNT_RESET;
		else
			counter_reg <= counter_next;
	end

	// modulo register; software resets the counter before writing
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			modulo_reg <= `MOD_RESET;
		else if (modulo_wr && !wait_active)
			modulo_reg <= modulo_wdata;
	end

	// value registers: a plain write takes effect at once
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			chan0_value_reg <= `CNT_RESET;
			chan1_value_reg <= `CNT_RESET;
		end
		else if (!wait_active)
		begin
			if (chan0_value_wr)
				chan0_value_reg <= value_wdata;
			if (chan1_value_wr)
				chan1_value_reg <= value_wdata;
		end
	end

	// buffered pairing: remember the last written value register
	always @*
	begin
		pending_next = pending_reg;
		active_next = active_chan_reg;
		if (!buffer_link_sel)
		begin
			// unlinked: channel 0 owns its pin again
			pending_next = 1'b0;
			active_next = 1'b0;
		end
		else
		begin
			if (!wait_active && chan1_value_wr)
				pending_next = 1'b1;
			else if (!wait_active && chan0_value_wr)
				pending_next = 1'b0;
			// switch only at a period boundary
			if (roll_ev)
				active_next = pending_next;
		end
	end

	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pending_reg <= 1'b0;
			active_chan_reg <= 1'b0;
		end
		else
		begin
			pending_reg <= pending_next;
			active_chan_reg <= active_next;
		end
	end

	// linked pin 0 compares against whichever register is active
	assign cmp0_val = (buffer_link_sel && active_chan_reg) ?
		chan1_value_reg : chan0_value_reg;

	assign els0 = {edge_level_sel_hi[0], edge_level_sel_lo[0]};
	assign els1 = {edge_level_sel_hi[1], edge_level_sel_lo[1]};

	// output compare mode needs a level code and the mode bit, or on channel 0 the link bit
	assign oc0 = (els0 != `ELS_OFF) &&
		(chan_mode_sel[0] || buffer_link_sel);
	assign oc1 = (els1 != `ELS_OFF) && chan_mode_sel[1] &&
		!buffer_link_sel;

	// compare looks at the count the tick is about to produce
	assign cmp_ev0 = tick && !counter_clear_bit && oc0 &&
		(count_after == cmp0_val);
	assign cmp_ev1 = tick && !counter_clear_bit && oc1 &&
		(count_after == chan1_value_reg);

	// pin logic for each channel
	chan_pin_logic u_pin0
	(
		.clk_sys     (clk_sys),
		.reset_n     (reset_n),
		.rollover_ev (roll_ev && oc0),
		.compare_ev  (cmp_ev0),
		.els         (els0),
		.mode_sel    (chan_mode_sel[0] || buffer_link_sel),
		.tov         (toggle_on_rollover[0]),
		.full_duty   (full_duty_sel[0]),
		.pin_reg     (chan0_pin)
	);

	chan_pin_logic u_pin1
	(
		.clk_sys     (clk_sys),
		.reset_n     (reset_n),
		.rollover_ev (roll_ev && oc1),
		.compare_ev  (cmp_ev1),
		.els         (els1),
		.mode_sel    (chan_mode_sel[1]),
		.tov         (toggle_on_rollover[1]),
		.full_duty   (full_duty_sel[1]),
		.pin_reg     (chan1_pin)
	);

	// channel 1 pin goes back to general i/o while linked
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			chan1_pin_en_reg <= 1'b0;
		else
			chan1_pin_en_reg <= !buffer_link_sel &&
				(els1 != `ELS_OFF);
	end

	// flag access is blocked in wait and in protected break
	assign acc_ok = !wait_active &&
		(!break_active || break_clear_enable);

	assign flag_set = {cmp_ev1, cmp_ev0, roll_ev};
	assign flag_rd = {chan_stat_rd, timer_stat_rd};
	assign flag_wr0 = {chan_flag_wr0, rollover_flag_wr0};

	// two-step clear per flag; a new set cancels an armed clear
	genvar gi;
	generate
		for (gi = 0; gi < `FLG_N; gi = gi + 1)
		begin : g_flag
			always @*
			begin
				flag_next[gi] = flag_reg[gi];
				armed_next[gi] = armed_reg[gi];
				if (flag_set[gi])
				begin
					flag_next[gi] = 1'b1;
					armed_next[gi] = 1'b0;
				end
				else if (acc_ok)
				begin
					// write of zero finishes an armed clear
					if (flag_wr0[gi] && armed_reg[gi])
						flag_next[gi] = 1'b0;
					if (flag_wr0[gi])
						armed_next[gi] = 1'b0;
					else if (flag_rd[gi] && flag_reg[gi])
						armed_next[gi] = 1'b1;
				end
				// protected break leaves flag and arm untouched
			end

			always @(posedge clk_sys or negedge reset_n)
			begin
				if (!reset_n)
				begin
					flag_reg[gi] <= 1'b0;
					armed_reg[gi] <= 1'b0;
				end
				else
				begin
					flag_reg[gi] <= flag_next[gi];
					armed_reg[gi] <= armed_next[gi];
				end
			end
		end
	endgenerate

	assign rollover_flag = flag_reg[`FLG_ROLL];
	assign chan_event_flag = flag_reg[`FLG_CH1:`FLG_CH0];

	// requests follow the flags gated by their enables
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rollover_irq_reg <= 1'b0;
			chan_irq_reg <= 2'h0;
			wake_req_reg <= 1'b0;
		end
		else
		begin
			rollover_irq_reg <= flag_next[`FLG_ROLL] &&
				rollover_irq_en;
			chan_irq_reg <= flag_next[`FLG_CH1:`FLG_CH0] &
				chan_irq_en;
			// any enabled request ends wait state
			wake_req_reg <= (flag_next[`FLG_ROLL] &&
				rollover_irq_en) ||
				|(flag_next[`FLG_CH1:`FLG_CH0] &
				chan_irq_en);
		end
	end

endmodule
`default_nettype wire

// ---- verif/timer_pwm_chk.sv ----
// timer_pwm_chk: port-level checker for the pwm timer
// assumes binding into timer_pwm_channel_logic, one clock domain
`timescale 1ns/1ps
`default_nettype none

module timer_pwm_chk
#(
	parameter CW = 16
)
(
	input wire logic          clk_sys,
	input wire logic          reset_n,
	input wire logic          counter_halt_bit,
	input wire logic          counter_clear_bit,
	input wire logic [2:0]    tick_divider_sel,
	input wire logic          stop_active,
	input wire logic          break_active,
	input wire logic          wait_active,
	input wire logic          break_clear_enable,
	input wire logic          rollover_irq_en,
	input wire logic [1:0]    chan_irq_en,
	input wire logic          chan0_value_wr,
	input wire logic [CW-1:0] value_wdata,
	input wire logic          buffer_link_sel,
	input wire logic [CW-1:0] counter_reg,
	input wire logic [CW-1:0] modulo_reg,
	input wire logic [CW-1:0] chan0_value_reg,
	input wire logic          rollover_flag,
	input wire logic [1:0]    chan_event_flag,
	input wire logic          rollover_irq_reg,
	input wire logic [1:0]    chan_irq_reg,
	input wire logic          wake_req_reg,
	input wire logic          chan1_pin_en_reg
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	// undivided tick with nothing holding the counter back
	wire go = !counter_halt_bit && !stop_active && !break_active &&
		tick_divider_sel == 3'h0 && !counter_clear_bit;

	// clear wins over everything, so it is left out of the freeze
	AST_FREEZE: assert property (
		(counter_halt_bit || stop_active || break_active ||
		tick_divider_sel == 3'h7) && !counter_clear_bit
		|=> $stable(counter_reg)) else $error("counter moved while held");
	AST_CLR: assert property (counter_clear_bit |=> counter_reg == '0)
		else $error("counter not cleared");
	AST_INC: assert property (go && counter_reg != modulo_reg
		|=> counter_reg == $past(counter_reg) + 1'b1)
		else $error("counter did not step");
	AST_ROLL: assert property (go && counter_reg == modulo_reg
		|=> counter_reg == '0 && rollover_flag)
		else $error("no rollover at modulo");
	// requests are registered from the next flag state, so they move
	// with the flag at the same edge, gated by the enable seen before it
	AST_TIRQ: assert property (rollover_irq_reg == (rollover_flag &&
		$past(rollover_irq_en))) else $error("rollover request wrong");
	AST_CIRQ: assert property (chan_irq_reg == (chan_event_flag &
		$past(chan_irq_en))) else $error("channel request wrong");
	AST_WAIT: assert property (wait_active && chan0_value_wr
		|=> $stable(chan0_value_reg)) else $error("write taken in wait");
	AST_WR: assert property (!wait_active && chan0_value_wr
		|=> chan0_value_reg == $past(value_wdata))
		else $error("value write not immediate");
	AST_LINK: assert property (buffer_link_sel ##1 buffer_link_sel
		|-> !chan1_pin_en_reg) else $error("channel one pin still owned");
	AST_HOLD: assert property ((wait_active || break_active &&
		!break_clear_enable) && rollover_flag |=> rollover_flag)
		else $error("protected flag cleared");
	AST_WAKE: assert property (wake_req_reg == (rollover_irq_reg ||
		|chan_irq_reg)) else $error("wake request wrong");
endmodule

bind timer_pwm_channel_logic timer_pwm_chk #(.CW(CW)) timer_pwm_chk_i (.*);

`default_nettype wire

// ---- verif/pin_sampler.sv ----
// pin_sampler: far-side load on a channel pin, counts high cycles
// assumes the pin is a registered level on clk_sys
`timescale 1ns/1ps
`default_nettype none

module pin_sampler
(
	input  wire logic        clk_sys,
	input  wire logic        clr,
	input  wire logic        pin,
	output var  logic [15:0] hi_cnt
);
	// window of whole periods makes the count phase independent
	always @(posedge clk_sys)
		if (clr)
			hi_cnt <= 16'h0000;
		else
			hi_cnt <= hi_cnt + {15'h0000, pin};
endmodule

`default_nettype wire

// ---- verif/tb_timer_pwm_channel_logic.sv ----
// tb_timer_pwm_channel_logic: self-checking bench for the pwm timer
// assumes pin_sampler and the bound checker are compiled with it
`timescale 1ns/1ps
`default_nettype none

module tb_timer_pwm_channel_logic;
	reg         clk_sys, reset_n, counter_halt_bit, counter_clear_bit, clr;
	reg         modulo_wr, chan0_value_wr, chan1_value_wr, buffer_link_sel;
	reg         rollover_irq_en, timer_stat_rd, rollover_flag_wr0;
	reg         wait_active, stop_active, break_active, break_clear_enable;
	reg  [2:0]  tick_divider_sel;
	reg  [15:0] modulo_wdata, value_wdata, hold, m, v;
	reg  [1:0]  chan_mode_sel, edge_level_sel_hi, edge_level_sel_lo;
	reg  [1:0]  toggle_on_rollover, full_duty_sel, chan_irq_en;
	reg  [1:0]  chan_stat_rd, chan_flag_wr0;
	reg  [31:0] seed;
	integer     mismatches, comparisons, i;
	wire [15:0] counter_reg, chan0_value_reg, hi_cnt;
	wire [15:0] chan1_value_reg;
	wire        chan1_pin;
	wire [1:0]  chan_event_flag;
	wire        active_chan_reg, rollover_flag, chan0_pin, chan1_pin_en_reg;

	timer_pwm_channel_logic timer_pwm_channel_logic_i
	(
		.modulo_reg       (),
		.rollover_irq_reg (),
		.chan_irq_reg     (),
		.wake_req_reg     (),
		.*
	);
	pin_sampler pin_sampler_i
	(
		.clk_sys (clk_sys),
		.clr     (clr),
		.pin     (chan0_pin),
		.hi_cnt  (hi_cnt)
	);

	// 50 MHz bus clock
	always #10 clk_sys = ~clk_sys;

	function [31:0] xs(input [31:0] x);
		reg [31:0] y;
		begin
			y = x ^ (x << 13);
			y = y ^ (y >> 17);
			xs = y ^ (y << 5);
		end
	endfunction
	// high cycles over two periods; compare action wins at rollover
	function [15:0] exp_hi(input [15:0] pm, pv, input [2:0] ps, input pp);
		exp_hi = ((pp ? pm + 16'h0001 - pv : pv) << ps) << 1;
	endfunction

	task chk(input [15:0] e, input [15:0] g);
		begin
			comparisons = comparisons + 1;
			if (g !== e)
			begin
				mismatches = mismatches + 1;
				$display("mismatch %0t exp %h got %h", $time, e, g);
			end
		end
	endtask
	task wv(input c, input [15:0] d);
		begin
			@(posedge clk_sys);
			chan0_value_wr <= !c;
			chan1_value_wr <= c;
			value_wdata <= d;
			@(posedge clk_sys);
			{chan0_value_wr, chan1_value_wr} <= 2'h0;
		end
	endtask
	// one status read and/or write-zero per flag: rollover, ch1, ch0
	task fl(input [2:0] r, input [2:0] w);
		begin
			@(posedge clk_sys);
			{timer_stat_rd, chan_stat_rd} <= r;
			{rollover_flag_wr0, chan_flag_wr0} <= w;
			@(posedge clk_sys);
			{timer_stat_rd, chan_stat_rd, rollover_flag_wr0, chan_flag_wr0} <= '0;
			@(posedge clk_sys);
			#1;
		end
	endtask
	// halt and clear first so the first period starts from zero
	task cfg(input [15:0] cm, cv, input [2:0] cs, input cp);
		begin
			@(posedge clk_sys);
			{counter_halt_bit, counter_clear_bit} <= 2'h3;
			@(posedge clk_sys);
			counter_clear_bit <= 1'b0;
			modulo_wr <= 1'b1;
			modulo_wdata <= cm;
			@(posedge clk_sys);
			modulo_wr <= 1'b0;
			wv(1'b0, cv);
			if (!buffer_link_sel)
				wv(1'b1, cv);
			tick_divider_sel <= cs;
			edge_level_sel_lo <= {cp, cp};
			counter_halt_bit <= 1'b0;
		end
	endtask
	// warm up two periods, then count over two periods
	task settle(input [15:0] p);
		begin
			repeat (2 * p) @(posedge clk_sys);
			clr <= 1'b1;
			@(posedge clk_sys);
			clr <= 1'b0;
			repeat (2 * p) @(posedge clk_sys);
			#1;
		end
	endtask
	task run_case(input [15:0] cm, cv, input [2:0] cs, input cp);
		begin
			cfg(cm, cv, cs, cp);
			settle((cm + 16'h0001) << cs);
			chk(exp_hi(cm, cv, cs, cp), hi_cnt);
		end
	endtask
	task print_verdict;
		begin
			if (mismatches == 0 && comparisons > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask

	// main sequence
	initial
	begin
		{counter_halt_bit, counter_clear_bit, modulo_wr, chan0_value_wr,
			chan1_value_wr, buffer_link_sel, rollover_irq_en, timer_stat_rd,
			rollover_flag_wr0, wait_active, stop_active, break_active,
			break_clear_enable, tick_divider_sel, modulo_wdata, value_wdata,
			edge_level_sel_lo, full_duty_sel, chan_irq_en, chan_stat_rd,
			chan_flag_wr0, clk_sys, reset_n, clr} = '0;
		{chan_mode_sel, edge_level_sel_hi, toggle_on_rollover} = 6'h3F;
		{mismatches, comparisons} = '0;
		seed = 32'h3670;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		run_case(16'h00FF, 16'h0080, 3'h0, 1'b0);
		run_case(16'h0005, 16'h0000, 3'h0, 1'b0);
		run_case(16'h0005, 16'h0006, 3'h1, 1'b1);
		for (i = 0; i < 8; i = i + 1)
		begin
			seed = xs(seed);
			m = 16'h0003 + seed[4:0];
			v = seed[10:5] % (m + 16'h0002);
			{rollover_irq_en, chan_irq_en} <= seed[18:16];
			run_case(m, v, {1'b0, seed[13:12]}, seed[20]);
		end
		run_case(16'h0003, 16'h0001, 3'h6, 1'b0);
		// code seven must give no tick, so the counter stands still
		tick_divider_sel <= 3'h7;
		repeat (2) @(posedge clk_sys);
		#1 hold = counter_reg;
		repeat (70) @(posedge clk_sys);
		#1 chk(hold, counter_reg);
		run_case(16'h0005, 16'h0003, 3'h0, 1'b0);
		// shorten right after the compare, lengthen right after rollover
		while (counter_reg != 16'h0003) @(posedge clk_sys) #1;
		wv(1'b0, 16'h0001);
		settle(16'h0006);
		chk(16'h0002, hi_cnt);
		while (counter_reg != 16'h0000) @(posedge clk_sys) #1;
		wv(1'b0, 16'h0004);
		settle(16'h0006);
		chk(16'h0008, hi_cnt);
		@(posedge clk_sys);
		toggle_on_rollover <= 2'h0;
		settle(16'h0006);
		chk(16'h0000, hi_cnt);
		chk(16'h0000, {15'h0000, chan1_pin});
		@(posedge clk_sys);
		{toggle_on_rollover, full_duty_sel} <= 4'hF;
		settle(16'h0006);
		chk(16'h000C, hi_cnt);
		chk(16'h0001, {15'h0000, chan1_pin});
		@(posedge clk_sys);
		{full_duty_sel, buffer_link_sel} <= 3'h1;
		run_case(16'h0009, 16'h0002, 3'h0, 1'b0);
		chk(16'h0004, {active_chan_reg, chan1_pin_en_reg, hi_cnt[13:0]});
		wv(1'b1, 16'h0007);
		settle(16'h000A);
		chk(16'h800E, {active_chan_reg, hi_cnt[14:0]});
		chk(16'h0007, chan1_value_reg);
		wv(1'b0, 16'h0004);
		settle(16'h000A);
		chk(16'h0008, {active_chan_reg, hi_cnt[14:0]});
		@(posedge clk_sys);
		wait_active <= 1'b1;
		wv(1'b0, 16'h00AA);
		wait_active <= 1'b0;
		#1 chk(16'h0004, chan0_value_reg);
		@(posedge clk_sys);
		stop_active <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 hold = counter_reg;
		repeat (5) @(posedge clk_sys);
		{stop_active, break_active} <= 2'h1;
		#1 chk(hold, counter_reg);
		// break alone, halt still clear, must also hold the count
		repeat (5) @(posedge clk_sys);
		{break_active, counter_halt_bit} <= 2'h1;
		#1 chk(hold, counter_reg);
		fl(3'h0, 3'h7);
		chk(16'h0007, {13'h0, rollover_flag, chan_event_flag});
		fl(3'h7, 3'h0);
		break_active <= 1'b1;
		fl(3'h0, 3'h7);
		chk(16'h0007, {13'h0, rollover_flag, chan_event_flag});
		break_clear_enable <= 1'b1;
		fl(3'h0, 3'h1);
		chk(16'h0006, {13'h0, rollover_flag, chan_event_flag});
		{break_active, break_clear_enable} <= 2'h0;
		// second step after the break finishes the armed clears
		fl(3'h0, 3'h6);
		chk(16'h0000, {13'h0, rollover_flag, chan_event_flag});
		print_verdict;
	end

	// watchdog: about seventeen times the expected run
	initial
	begin
		#1500000;
		mismatches = mismatches + 1;
		print_verdict;
	end
endmodule

`default_nettype wire
